// ---- rtl/status_byte_pkg.sv ----
// constants shared by the status byte generator files
`default_nettype none
package status_byte_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [10:0] CTRL_RESET = 11'h000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [31:0] READ_ZERO = 32'h00000000;
    // control register fields
    localparam int CTRL_W = 11;
    localparam int CTRL_PLUS_PD = 0;
    localparam int CTRL_MINUS_PD = 1;
    localparam int CTRL_XCVR_LSB = 2;
    localparam int CTRL_TERM = 4;
    localparam int CTRL_OPMODE_LSB = 5;
    localparam int CTRL_BV_RISE = 7;
    localparam int CTRL_BV_FALL = 8;
    localparam int CTRL_FAULT_EN = 9;
    localparam int CTRL_LOW_POWER = 10;
    // status register fields
    localparam int STAT_SENT_LSB = 0;
    localparam int STAT_NOW_LSB = 8;
    localparam int STAT_PENDING = 16;
    localparam int STAT_DIR = 17;
    localparam int STAT_BUS_LSB = 24;
    // ------------------------------------------------------------
    // status byte layout and codes
    // ------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int LS_LSB = 0;
    localparam int VBUS_LSB = 2;
    localparam int RXEV_LSB = 4;
    localparam int RSVD_BIT = 6;
    localparam int ALT_BIT = 7;
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_ONE = 2'h1;
    localparam logic [1:0] LS_TWO = 2'h2;
    localparam logic [1:0] VBUS_BELOW_END = 2'h0;
    localparam logic [1:0] VBUS_ABOVE_END = 2'h1;
    localparam logic [1:0] VBUS_SESSION = 2'h2;
    localparam logic [1:0] VBUS_A_VALID = 2'h3;
    localparam logic [1:0] RXEV_IDLE = 2'h0;
    localparam logic [1:0] RXEV_ACTIVE = 2'h1;
    localparam logic [1:0] RXEV_DISCON = 2'h2;
    localparam logic [1:0] RXEV_ERROR = 2'h3;
    localparam logic [1:0] XCVR_HS = 2'h0;
    localparam logic [1:0] OPMODE_CHIRP = 2'h2;
    // ------------------------------------------------------------
    // synchroniser bit positions
    // ------------------------------------------------------------
    localparam int SYNC_W = 21;
    localparam int S_DP = 0;
    localparam int S_DM = 1;
    localparam int S_SQUELCH = 2;
    localparam int S_HS_DIFF = 3;
    localparam int S_SESSION_END_INDICATOR = 4;
    localparam int S_SESS_VALID = 5;
    localparam int S_A_VALID = 6;
    localparam int S_FAULT = 7;
    localparam int S_RX_ACTIVE = 8;
    localparam int S_RX_ERROR = 9;
    localparam int S_HOST_DISC = 10;
    localparam int S_BVALID = 11;
    localparam int S_LINK_CLK = 12;
    localparam int S_BUS_LSB = 13;
    // link side states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TURN = 2'b01,
        ST_BYTE = 2'b10
    } link_state_e;
endpackage
`default_nettype wire

// ---- rtl/sync_if.sv ----
// carries raw pin levels into the synchroniser and the clean levels back
`default_nettype none
interface sync_if;
    logic [status_byte_pkg::SYNC_W-1:0] raw;
    logic [status_byte_pkg::SYNC_W-1:0] synced;
    modport user (output raw, input synced);
    modport sync (input raw, output synced);
endinterface
`default_nettype wire

// ---- rtl/input_sync.sv ----
// two flip-flop synchroniser for every asynchronous input bit
`default_nettype none
module input_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    sync_if.sync port
);
    import status_byte_pkg::*;

    logic [SYNC_W-1:0] first_reg;
    logic [SYNC_W-1:0] second_reg;

    // ------------------------------------------------------------
    // per-bit chain, first stage read only by second
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < SYNC_W; i++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    first_reg[i] <= 1'b0;
                    second_reg[i] <= 1'b0;
                end else begin
                    first_reg[i] <= port.raw[i];
                    second_reg[i] <= first_reg[i];
                end
            end
        end
    endgenerate

    assign port.synced = second_reg;
endmodule
`default_nettype wire

// ---- rtl/ulpi_status_byte_generator.sv ----
// status byte generator: builds and sends the link status byte
`default_nettype none
// What this block does
// RULE1 - to report status, raise direction, then drive one status byte on data.
// RULE2 - send a fresh status byte by itself whenever any field changes.
// RULE3 - the link accepts status bytes anytime, single, back to back or mid-packet.
// RULE4 - after low power or serial mode, skip the byte if the cause vanished.
// RULE5 - line state in bits 1:0, supply state 3:2, receive event 5:4.
// RULE6 - enabled rising or falling b-session changes send a byte with bit 7 set.
// RULE7 - line state follows the data lines; each change sends a new byte.
// RULE8 - peripheral full speed: 00 SE0, 01 J, 10 K, 11 SE1.
// RULE9 - peripheral high speed: 00 squelch, 01 no squelch.
// RULE10 - chirp: 00 squelch, 01 diff output high, 10 diff output low.
// RULE11 - host pulldowns both on select host decode; chirp by operating mode 10.
// RULE12 - host low speed: 00 SE0, 01 K, 10 J, 11 SE1; full speed as peripheral.
// RULE13 - a dual-role link picks the decode table of its current role.
// RULE14 - supply state comes straight from the three comparator outputs.
// RULE15 - supply code 00 end, 01 above end, 10 session valid, 11 a-device valid.
// RULE16 - the shared supply pin is used for sensing or fault, never both.
// RULE17 - receive event 00 idle, 01 active, 11 active error, 10 disconnect.
// RULE18 - with fault enabled, fault replaces a-device valid and changes send bytes.
// RULE19 - reserved bit 6 is driven as zero.
// RULE20 - one turnaround cycle after raising direction before the byte is valid.
module ulpi_status_byte_generator (
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // link pins
    input wire logic ulpi_clk_i,
    output logic ulpi_dir_o,
    input wire logic [status_byte_pkg::BYTE_W-1:0] ulpi_data_i,
    output logic [status_byte_pkg::BYTE_W-1:0] ulpi_data_o,
    output logic ulpi_data_oe_o,
    // analog front end levels
    input wire logic dp_i,
    input wire logic dm_i,
    input wire logic squelch_i,
    input wire logic hs_diff_i,
    input wire logic session_end_indicator_i,
    input wire logic session_valid_indicator_i,
    input wire logic a_device_supply_valid_i,
    input wire logic fault_i,
    input wire logic rx_active_i,
    input wire logic rx_error_i,
    input wire logic host_disconnect_i,
    input wire logic bvalid_i
);
    import status_byte_pkg::*;

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    sync_if sif ();

    assign sif.raw = {ulpi_data_i, ulpi_clk_i, bvalid_i, host_disconnect_i,
                      rx_error_i, rx_active_i, fault_i, a_device_supply_valid_i,
                      session_valid_indicator_i, session_end_indicator_i,
                      hs_diff_i, squelch_i, dm_i, dp_i};

    input_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .port(sif.sync)
    );

    logic [SYNC_W-1:0] s;
    assign s = sif.synced;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [15:0] count_reg, count_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;

    logic plus_line_pulldown_enable;
    logic minus_line_pulldown_enable;
    logic [1:0] xcvr_sel;
    logic term_sel;
    logic [1:0] opmode;
    logic bv_rise_en;
    logic bv_fall_en;
    logic fault_en;
    logic low_power;

    assign plus_line_pulldown_enable = ctrl_reg[CTRL_PLUS_PD];
    assign minus_line_pulldown_enable = ctrl_reg[CTRL_MINUS_PD];
    assign xcvr_sel = ctrl_reg[CTRL_XCVR_LSB +: 2];
    assign term_sel = ctrl_reg[CTRL_TERM];
    assign opmode = ctrl_reg[CTRL_OPMODE_LSB +: 2];
    assign bv_rise_en = ctrl_reg[CTRL_BV_RISE];
    assign bv_fall_en = ctrl_reg[CTRL_BV_FALL];
    assign fault_en = ctrl_reg[CTRL_FAULT_EN];
    assign low_power = ctrl_reg[CTRL_LOW_POWER];

    // ------------------------------------------------------------
    // line state decode
    // ------------------------------------------------------------
    logic host_role;
    logic hs_select;
    logic [1:0] line_state;
    logic [1:0] squelch_code;
    logic [1:0] chirp_code;

    // host decode only when both pulldowns are on
    assign host_role = plus_line_pulldown_enable & minus_line_pulldown_enable; // RULE11

    assign hs_select = (xcvr_sel == XCVR_HS);
    assign squelch_code = s[S_SQUELCH] ? LS_SE0 : LS_ONE; // RULE9
    assign chirp_code = s[S_SQUELCH] ? LS_SE0 :
                        (s[S_HS_DIFF] ? LS_ONE : LS_TWO); // RULE10

    always_comb begin
        // full and low speed report the lines directly as {dm, dp}
        line_state = {s[S_DM], s[S_DP]}; // RULE7 RULE8 RULE12
        if (hs_select) begin
            if (host_role) begin
                if (!term_sel) begin
                    if (opmode == OPMODE_CHIRP) begin
                        line_state = chirp_code; // RULE11
                    end else begin
                        line_state = squelch_code; // RULE11
                    end
                end
            end else begin
                if (term_sel) begin
                    line_state = chirp_code; // RULE10
                end else begin
                    line_state = squelch_code; // RULE9
                end
            end
        end
    end

    // ------------------------------------------------------------
    // supply state and receive event
    // ------------------------------------------------------------
    logic a_valid_src;
    logic [1:0] vbus_state;
    logic [1:0] rx_event;

    // fault pin stands in for the a-device comparator
    assign a_valid_src = fault_en ? s[S_FAULT] : s[S_A_VALID]; // RULE18

    always_comb begin
        if (a_valid_src) begin
            vbus_state = VBUS_A_VALID; // RULE14 RULE15
        end else if (s[S_SESS_VALID]) begin
            vbus_state = VBUS_SESSION; // RULE15
        end else if (s[S_SESSION_END_INDICATOR]) begin
            vbus_state = VBUS_BELOW_END; // RULE15
        end else begin
            vbus_state = VBUS_ABOVE_END; // RULE15
        end
    end

    always_comb begin
        if (host_role && s[S_HOST_DISC]) begin
            rx_event = RXEV_DISCON; // RULE17
        end else if (s[S_RX_ACTIVE]) begin
            rx_event = s[S_RX_ERROR] ? RXEV_ERROR : RXEV_ACTIVE; // RULE17
        end else begin
            rx_event = RXEV_IDLE; // RULE17
        end
    end

    logic [5:0] fields_now;
    assign fields_now = {rx_event, vbus_state, line_state}; // RULE5

    // ------------------------------------------------------------
    // change detection
    // ------------------------------------------------------------
    logic [5:0] sent_reg, sent_next;
    logic bvalid_reg, bvalid_next;
    logic alt_reg, alt_next;
    logic link_clk_reg, link_clk_next;
    logic bv_event;
    logic field_change;
    logic link_edge;
    logic send_now;
    logic [BYTE_W-1:0] byte_now;

    assign link_edge = s[S_LINK_CLK] & ~link_clk_reg;
    assign bv_event = (bv_rise_en & s[S_BVALID] & ~bvalid_reg) |
                      (bv_fall_en & ~s[S_BVALID] & bvalid_reg); // RULE6
    // compared against what the link last saw, so a cause gone before
    // low power ends leaves nothing to send
    assign field_change = (fields_now != sent_reg); // RULE2 RULE4

    always_comb begin
        byte_now = '0;
        byte_now[LS_LSB +: 2] = line_state; // RULE5
        byte_now[VBUS_LSB +: 2] = vbus_state; // RULE5
        byte_now[RXEV_LSB +: 2] = rx_event; // RULE5
        byte_now[RSVD_BIT] = 1'b0; // RULE19
        byte_now[ALT_BIT] = alt_reg | bv_event; // RULE6
    end

    // ------------------------------------------------------------
    // link side sequencing
    // ------------------------------------------------------------
    link_state_e state_reg, state_next;
    logic dir_reg, dir_next;
    logic oe_reg, oe_next;
    logic [BYTE_W-1:0] data_reg, data_next;
    logic want_send;

    assign want_send = ~low_power & (field_change | alt_reg | bv_event);

    always_comb begin
        state_next = state_reg;
        dir_next = dir_reg;
        oe_next = oe_reg;
        data_next = data_reg;
        sent_next = sent_reg;
        send_now = 1'b0;
        link_clk_next = s[S_LINK_CLK];
        bvalid_next = s[S_BVALID];
        if (link_edge) begin
            case (state_reg)
                ST_IDLE: begin
                    if (want_send) begin
                        state_next = ST_TURN;
                        dir_next = 1'b1; // RULE1
                    end
                end
                ST_TURN: begin
                    // bus turned round, byte now valid
                    state_next = ST_BYTE; // RULE20
                    oe_next = 1'b1;
                    data_next = byte_now; // RULE1
                    sent_next = fields_now;
                    send_now = 1'b1;
                end
                ST_BYTE: begin
                    if (want_send) begin
                        data_next = byte_now; // RULE2
                        sent_next = fields_now;
                        send_now = 1'b1;
                    end else begin
                        state_next = ST_IDLE;
                        dir_next = 1'b0;
                        oe_next = 1'b0;
                        data_next = '0;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    dir_next = 1'b0;
                    oe_next = 1'b0;
                    data_next = '0;
                end
            endcase
        end
    end

    // alternate flag: in a send cycle the clear wins over a new event, which goes out in that byte
    always_comb begin
        alt_next = alt_reg;
        if (send_now) begin
            alt_next = 1'b0;
        end
        if (low_power) begin
            alt_next = 1'b0; // RULE4
        end else if (bv_event && !send_now) begin
            alt_next = 1'b1; // RULE6
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            dir_reg <= 1'b0;
            oe_reg <= 1'b0;
            data_reg <= '0;
            sent_reg <= '0;
            alt_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            link_clk_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            dir_reg <= dir_next;
            oe_reg <= oe_next;
            data_reg <= data_next;
            sent_reg <= sent_next;
            alt_reg <= alt_next;
            bvalid_reg <= bvalid_next;
            link_clk_reg <= link_clk_next;
        end
    end

    assign ulpi_dir_o = dir_reg;
    assign ulpi_data_oe_o = oe_reg;
    assign ulpi_data_o = data_reg;

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic wb_req;
    logic [31:0] status_word;

    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;

    always_comb begin
        status_word = READ_ZERO;
        status_word[STAT_SENT_LSB +: BYTE_W] = data_reg;
        status_word[STAT_NOW_LSB +: BYTE_W] = byte_now;
        status_word[STAT_PENDING] = want_send;
        status_word[STAT_DIR] = dir_reg;
        status_word[STAT_BUS_LSB +: BYTE_W] = s[S_BUS_LSB +: BYTE_W];
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        count_next = send_now ? count_reg + 16'h0001 : count_reg;
        rdata_next = READ_ZERO;
        ack_next = wb_req;
        if (wb_req) begin
            case (wb_adr_i)
                ADDR_CTRL: begin
                    rdata_next[CTRL_W-1:0] = ctrl_reg;
                    if (wb_we_i) begin
                        if (wb_sel_i[0]) begin
                            ctrl_next[7:0] = wb_dat_i[7:0];
                        end
                        if (wb_sel_i[1]) begin
                            ctrl_next[CTRL_W-1:8] = wb_dat_i[CTRL_W-1:8];
                        end
                    end
                end
                ADDR_STATUS: begin
                    rdata_next = status_word;
                end
                ADDR_COUNT: begin
                    rdata_next[15:0] = count_reg;
                    if (wb_we_i && !send_now) begin
                        count_next = COUNT_RESET;
                    end
                end
                default: begin
                    rdata_next = READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RESET;
            count_reg <= COUNT_RESET;
            rdata_reg <= READ_ZERO;
            ack_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            count_reg <= count_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
        end
    end

    assign wb_dat_o = rdata_reg;
    assign wb_ack_o = ack_reg;
endmodule
`default_nettype wire

// ---- tb/status_byte_assertions.sv ----
// port-level checks for the status byte generator
`default_nettype none
module status_byte_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic ulpi_dir_o,
    input wire logic [status_byte_pkg::BYTE_W-1:0] ulpi_data_o,
    input wire logic ulpi_data_oe_o
);
    timeunit 1ns / 1ns;
    import status_byte_pkg::*;
    logic [10:0] ctl_reg;
    logic [10:0] ctl_next;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // control shadow, taken on the request edge
    // ------------------------------------------------------------
    always_comb begin
        ctl_next = ctl_reg;
        if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == ADDR_CTRL) begin
            if (wb_sel_i[0]) ctl_next[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) ctl_next[10:8] = wb_dat_i[10:8];
        end
    end
    always_ff @(posedge clk_i) begin
        ctl_reg <= rst_i ? CTRL_RESET : ctl_next;
    end
    sequence turnaround_s;
        !ulpi_data_oe_o [*7] ##[1:3] ulpi_data_oe_o;
    endsequence
    oe_needs_dir_a: assert property (ulpi_data_oe_o |-> ulpi_dir_o)
        else $error("data driven without direction");
    turnaround_cycle_a: assert property ($rose(ulpi_dir_o) |-> turnaround_s)
        else $error("no turnaround before status byte");
    rsvd_zero_a: assert property (ulpi_data_oe_o |-> !ulpi_data_o[RSVD_BIT])
        else $error("reserved bit set");
    byte_holds_a: assert property (ulpi_data_oe_o && $changed(ulpi_data_o) |=>
        $stable(ulpi_data_o) [*6])
        else $error("status byte changed early");
    release_together_a: assert property ($fell(ulpi_data_oe_o) |-> !ulpi_dir_o)
        else $error("direction kept after release");
    alt_enabled_a: assert property (ulpi_data_oe_o && ulpi_data_o[ALT_BIT] |->
        ctl_reg[CTRL_BV_RISE] || ctl_reg[CTRL_BV_FALL])
        else $error("alternate flag while disabled");
    quiet_low_power_a: assert property (ctl_reg[CTRL_LOW_POWER] |-> !$rose(ulpi_dir_o))
        else $error("bus taken in low power");
    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
endmodule
bind ulpi_status_byte_generator status_byte_assertions chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .ulpi_dir_o(ulpi_dir_o), .ulpi_data_o(ulpi_data_o),
    .ulpi_data_oe_o(ulpi_data_oe_o)
);
`default_nettype wire

// ---- tb/link_partner.sv ----
// link controller model taking status bytes off the data bus
`default_nettype none
module link_partner (
    input wire logic ulpi_clk_i,
    input wire logic dir_i,
    input wire logic oe_i,
    input wire logic [7:0] data_i,
    output logic [7:0] bus_o,
    output logic [7:0] rx_byte_o,
    output logic [15:0] rx_count_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] held = 8'h5A;
    logic dir_q = 1'h0;
    // idle 00 while link owns the bus, changing junk when released
    assign bus_o = oe_i ? data_i : (dir_i ? ~held : 8'h00);
    initial begin
        rx_count_o = 16'h0000;
        rx_byte_o = 8'h00;
    end
    always @(posedge ulpi_clk_i) begin
        held <= bus_o;
        dir_q <= dir_i;
        if (dir_i && dir_q && oe_i) begin
            rx_byte_o <= data_i;
            rx_count_o <= rx_count_o + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ---- tb/ulpi_status_byte_generator_tb.sv ----
// self-checking bench for the status byte generator
`default_nettype none
module ulpi_status_byte_generator_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import status_byte_pkg::*;
    logic clk_i = 0;
    logic ulpi_clk = 0;
    logic rst_i = 1;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] dout_wb;
    logic [31:0] rdat;
    logic ack;
    logic dir;
    logic oe;
    logic [7:0] dout;
    logic [7:0] bus;
    logic [7:0] rx_byte;
    logic [15:0] rx_count;
    logic [15:0] seen = 16'h0;
    logic [11:0] pins = 12'h010;
    logic [10:0] ctl = 11'h000;
    logic [7:0] last = 8'h00;
    logic [7:0] q[$];
    logic [2:0] vt[4] = '{3'h1, 3'h0, 3'h2, 3'h4};
    logic [2:0] et[4] = '{3'h0, 3'h1, 3'h3, 3'h4};
    logic [10:0] modes[7] = '{11'h014, 11'h017, 11'h01B, 11'h000, 11'h010, 11'h003, 11'h043};
    int miscompares = 0;
    int samples_checked = 0;
    int sent = 0;
    always #50 clk_i = ~clk_i;
    initial #137 forever #400 ulpi_clk = ~ulpi_clk;
    ulpi_status_byte_generator dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout_wb), .wb_ack_o(ack),
        .ulpi_clk_i(ulpi_clk), .ulpi_dir_o(dir), .ulpi_data_i(bus), .ulpi_data_o(dout),
        .ulpi_data_oe_o(oe), .dp_i(pins[0]), .dm_i(pins[1]), .squelch_i(pins[2]),
        .hs_diff_i(pins[3]), .session_end_indicator_i(pins[4]),
        .session_valid_indicator_i(pins[5]), .a_device_supply_valid_i(pins[6]),
        .fault_i(pins[7]), .rx_active_i(pins[8]), .rx_error_i(pins[9]),
        .host_disconnect_i(pins[10]), .bvalid_i(pins[11])
    );
    link_partner link_u (
        .ulpi_clk_i(ulpi_clk), .dir_i(dir), .oe_i(oe), .data_i(dout), .bus_o(bus),
        .rx_byte_o(rx_byte), .rx_count_o(rx_count)
    );
    function automatic logic [7:0] encode(input logic [11:0] p, input logic [10:0] c);
        logic host;
        logic hs;
        logic [1:0] ls;
        logic [1:0] vb;
        logic [1:0] ev;
        host = c[0] & c[1];
        hs = c[3:2] == 2'h0;
        ls = {p[1], p[0]};
        if (hs && (host ? !c[4] && c[6:5] == 2'h2 : c[4]))
            ls = p[2] ? 2'h0 : {!p[3], p[3]};
        else if (hs && !c[4])
            ls = {1'h0, !p[2]};
        vb = (c[9] ? p[7] : p[6]) ? 2'h3 : p[5] ? 2'h2 : p[4] ? 2'h0 : 2'h1;
        ev = host && p[10] ? 2'h2 : {p[8] & p[9], p[8]};
        return {2'h0, ev, vb, ls};
    endfunction
    task automatic err(input string msg);
        miscompares++;
        $display("[ERR] %0t %s", $time, msg);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
            err($sformatf("%s got %h exp %h", what, got, exp));
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 50);
        rdat = dout_wb;
        cyc <= 1'h0;
        stb <= 1'h0;
        if (n == 50)
            err("bus cycle timed out");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        cmp(rdat, e, "register");
    endtask
    task automatic settle();
        int n;
        repeat (24) @(posedge clk_i);
        for (n = 0; n < 300 && (q.size() != 0 || dir !== 1'h0); n++) @(posedge clk_i);
        if (n == 300)
            err("bus did not settle");
    endtask
    task automatic step(input logic [11:0] p, input logic alt, input logic quick);
        logic [7:0] e;
        int n;
        @(posedge clk_i);
        pins <= p;
        e = encode(p, ctl) | {alt, 7'h00};
        if (!ctl[10] && (alt || e[5:0] != last[5:0])) begin
            q.push_back(e);
            last = e;
            sent++;
        end
        if (quick)
            for (n = 0; n < 50 && oe !== 1'h1; n++) @(posedge clk_i);
        else
            settle();
    endtask
    task automatic set_ctl(input logic [10:0] c);
        wb(1'h1, ADDR_CTRL, {21'h0, c});
        ctl = c;
        step(pins, 1'h0, 1'h0);
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(negedge ulpi_clk) begin
        if (rx_count !== seen) begin
            seen = rx_count;
            if (q.size() == 0)
                err("unexpected status byte");
            else
                cmp(rx_byte, q.pop_front(), "status byte");
        end
    end
    initial begin
        logic [31:0] r;
        logic [11:0] p;
        void'($urandom(3291));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(ADDR_CTRL, 32'h0);
        for (int m = 0; m < 7; m++) begin
            set_ctl(modes[m]);
            for (int j = 0; j < 4; j++) begin
                r = $urandom;
                p = pins;
                p[3:0] = modes[m][3:2] == 2'h0 ? {j[1:0], r[1:0]} : {r[1:0], j[1:0]};
                p[6:4] = vt[(j + m) % 4];
                p[10:8] = et[(j + m) % 4];
                step(p, 1'h0, 1'h0);
            end
        end
        p = pins;
        p[6:4] = 3'h4;
        step(p, 1'h0, 1'h1);
        p[6:4] = 3'h1;
        step(p, 1'h0, 1'h0);
        set_ctl(ctl | 11'h080);
        step(pins | 12'h800, 1'h1, 1'h0);
        step(pins & 12'h7FF, 1'h0, 1'h0);
        set_ctl(ctl ^ 11'h180);
        step(pins | 12'h800, 1'h0, 1'h0);
        step(pins & 12'h7FF, 1'h1, 1'h0);
        // fault replaces supply valid, which stays low meanwhile
        set_ctl(ctl ^ 11'h300);
        step(pins | 12'h080, 1'h0, 1'h0);
        step(pins & 12'hF7F, 1'h0, 1'h0);
        set_ctl(ctl ^ 11'h600);
        step(pins ^ 12'h004, 1'h0, 1'h0);
        step(pins ^ 12'h004, 1'h0, 1'h0);
        set_ctl(ctl ^ 11'h400);
        set_ctl(ctl ^ 11'h400);
        step(pins ^ 12'h004, 1'h0, 1'h0);
        set_ctl(ctl ^ 11'h400);
        rd(ADDR_COUNT, {16'h0, sent[15:0]});
        wb(1'h1, ADDR_COUNT, 32'hFFFFFFFF);
        rd(ADDR_COUNT, 32'h0);
        wb(1'h0, ADDR_STATUS, 32'h0);
        cmp(rdat, {16'h0, 2'h0, last[5:0], 8'h00}, "status");
        wb(1'h1, 8'h0C, 32'h7FF);
        rd(8'h0C, 32'h0);
        rd(ADDR_CTRL, {21'h0, ctl});
        wrap_up();
    end
    initial begin
        #2000000;
        err("watchdog expired");
        wrap_up();
    end
endmodule
`default_nettype wire
